// ==== inc/der_pkg.sv ====
/*
  Shared constants, register map and types for the diagnostic error
  reporting block. Assumes a 250 MHz APB clock.
*/
package der_pkg;

  localparam int CLK_MHZ = 250;
  localparam int LED_MIN_ON_S = 3;
  localparam longint LED_MIN_CYCLES_L =
    longint'(LED_MIN_ON_S) * longint'(CLK_MHZ) * 64'd1000000;
  localparam int LED_MIN_CYCLES = int'(LED_MIN_CYCLES_L);

  localparam int NUM_FAULTS = 12;
  localparam int BUF_DEPTH = 8;
  localparam int BUF_AW = 3;

  // Fault vector positions
  localparam int F_IRQ_LOST = 0;
  localparam int F_WATCHDOG = 1;
  localparam int F_UNCONFIG = 2;
  localparam int F_BAD_PARAM = 3;
  localparam int F_NO_AUX = 4;
  localparam int F_NO_FRONT = 5;
  localparam int F_WIRE_BRK = 6;
  localparam int F_OPERATING = 7;
  localparam int F_FRAME = 8;
  localparam int F_PULSE_ZERO = 9;
  localparam int F_TRAVEL = 10;
  localparam int F_SET_ACT = 11;

  // Faults that raise a diagnostic interrupt
  localparam logic [11:0] DIAG_MASK = 12'hFF8 | 12'h008;
  // Faults that clear synchronisation
  localparam logic [11:0] SYNC_MASK = 12'hE60 | 12'h010;

  // APB register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_FAULTS = 8'h08;
  localparam logic [7:0] A_INFO = 8'h0C;
  localparam logic [7:0] A_BUF_CNT = 8'h10;
  localparam logic [7:0] A_BUF_DATA = 8'h14;
  localparam logic [7:0] A_FLAGS = 8'h18;

  // CTRL bits
  localparam int C_DIAG_EN = 0;
  localparam int C_SYSBLK_PARAM = 1;
  localparam int C_BUF_POP = 2;
  localparam int C_FLAG_CLR = 3;

  localparam logic [7:0] MOD_ADDR_DEF = 8'h10;  // Arbitrary default

  typedef struct packed {
    logic [7:0] err_class;
    logic [7:0] err_number;
  } der_entry_t;

  typedef struct packed {
    logic valid;
    logic entering;
    logic module_defect;
    logic [7:0] module_addr;
  } der_irq_t;

endpackage : der_pkg

// ==== logic/der_core.sv ====
/*
  Diagnostic error reporting: fault aggregation, group fault indicator,
  diagnostic buffer, entering/leaving interrupt events and error reactions.
  Assumes fault inputs and host run state come from pins (synchronised
  here) and job error strobes from logic on pclk.
*/
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module der_core
  import der_pkg::*;
#(
  parameter int LED_CYCLES = LED_MIN_CYCLES,
  parameter int DEPTH = BUF_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_FAULTS-1:0] fault_in,
  input wire logic host_run,
  input wire logic sw_limit_passed,
  input wire logic sim_mode,
  input wire logic [7:0] control_in,
  input wire logic dir_change_req,
  input wire logic [7:0] func_sw_in,
  input wire logic write_job_data_err,
  input wire logic host_comm_err,
  input wire logic irq_ack,
  output logic group_fault_indicator,
  output logic cam_run,
  output logic sync_clear,
  output logic [7:0] control_out,
  output logic dir_change_out,
  output logic [7:0] func_sw_out,
  output der_irq_t irq
);

  // Pointer widths come from the package, so depth is fixed
  if (DEPTH != BUF_DEPTH || LED_CYCLES < 1) begin : g_bad_param
    $error("der_core: unsupported parameters");
  end

  typedef struct packed {
    logic [NUM_FAULTS-1:0] s1, s2, prev;
    logic run1, run2, run_prev;
    logic [31:0] led_cnt;
    logic led;
    logic diag_en, sysblk_param;
    logic [7:0] mod_addr;
    logic cam_run, sync_clr;
    logic [7:0] ctl_out;
    logic dir_out;
    logic [7:0] fsw_out;
    logic data_err, job_err;
    logic reported;           // Host has seen an entering event
    der_irq_t irq;
    logic [BUF_AW-1:0] wp, rp;
    logic [BUF_AW:0] cnt;
    logic [31:0] rdata;
  } der_state_t;

  der_state_t r, next_r;
  der_entry_t buffer [DEPTH];
  logic buf_push;
  der_entry_t buf_entry;

  function automatic logic [3:0] first_set(input logic [NUM_FAULTS-1:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = NUM_FAULTS - 1; i >= 0; i--) begin
      if (v[i]) idx = 4'(i);
    end
    return idx;
  endfunction : first_set

  logic [NUM_FAULTS-1:0] eff, diag_f, new_f;
  logic any_diag, fresh, gone_some, run_rise, wr, rd, acc;

  always_comb begin
    eff = r.s2;
    // Bad parameters count only when loaded from system data block
    eff[F_BAD_PARAM] = r.s2[F_BAD_PARAM] & r.sysblk_param;
    diag_f = eff & DIAG_MASK;
    new_f = diag_f & ~r.prev;
    any_diag = |diag_f;
    fresh = |new_f;
    gone_some = |(r.prev & ~diag_f);
    run_rise = r.run2 & ~r.run_prev;
    acc = psel & penable;
    wr = acc & pwrite;
    rd = acc & ~pwrite;
  end

  assign pready = 1'b1;
  assign pslverr = 1'b0;

  always_comb begin
    next_r = r;
    buf_push = 1'b0;
    buf_entry = '0;
    next_r.s1 = fault_in;
    next_r.s2 = r.s1;
    next_r.run1 = host_run;
    next_r.run2 = r.run1;
    next_r.run_prev = r.run2;
    next_r.prev = diag_f;
    next_r.irq.valid = 1'b0;

    // Retriggered on each new fault, held while anything pends
    if (|(eff & ~r.prev)) begin
      next_r.led_cnt = 32'(LED_CYCLES);
    end else if (r.led_cnt != 32'h0) begin
      next_r.led_cnt = r.led_cnt - 32'h1;
    end
    next_r.led = (|eff) | (next_r.led_cnt != 32'h0);

    if (fresh) begin
      buf_push = 1'b1;
      buf_entry.err_class = any_diag ? 8'h01 : 8'h00;
      buf_entry.err_number = 8'(first_set(new_f)) + 8'h01;
      next_r.cam_run = 1'b0;
    end
    if (!any_diag) next_r.cam_run = 1'b1;
    next_r.sync_clr = |(eff & SYNC_MASK);

    // Control held, direction change blocked unless limit passed in sim mode, while a diagnostic error pends; function switches pass
    next_r.ctl_out = any_diag ? r.ctl_out : control_in;
    next_r.dir_out = (!any_diag || (sw_limit_passed && sim_mode))
                     ? dir_change_req : 1'b0;
    next_r.fsw_out = func_sw_in;

    // Events only when enabled and the host runs
    if (r.diag_en && r.run2) begin
      if (any_diag && (fresh || gone_some || run_rise || !r.reported)) begin
        next_r.irq.valid = 1'b1;
        next_r.irq.entering = 1'b1;
        next_r.reported = 1'b1;
      end else if (!any_diag && r.reported && !run_rise) begin
        next_r.irq.valid = 1'b1;
        next_r.irq.entering = 1'b0;
        next_r.reported = 1'b0;
      end
      next_r.irq.module_defect = any_diag;
      next_r.irq.module_addr = r.mod_addr;
    end
    if (run_rise && !any_diag) next_r.reported = 1'b0;
    if (irq_ack) next_r.irq.valid = 1'b0;

    // Sticky job flags; set beats clear
    if (wr && paddr[7:0] == A_CTRL && pwdata[C_FLAG_CLR]) begin
      next_r.data_err = 1'b0;
      next_r.job_err = 1'b0;
    end
    if (write_job_data_err) next_r.data_err = 1'b1;
    if (host_comm_err) next_r.job_err = 1'b1;

    if (wr) begin
      unique case (paddr[7:0])
        A_CTRL: begin
          next_r.diag_en = pwdata[C_DIAG_EN];
          next_r.sysblk_param = pwdata[C_SYSBLK_PARAM];
        end
        A_INFO: next_r.mod_addr = pwdata[7:0];
        default: ;
      endcase
    end

    // Buffer: push from faults, pop by software
    if (buf_push) begin
      next_r.wp = r.wp + BUF_AW'(1);
      if (r.cnt == (BUF_AW+1)'(DEPTH)) next_r.rp = r.rp + BUF_AW'(1);
      else next_r.cnt = r.cnt + (BUF_AW+1)'(1);
    end else if (wr && paddr[7:0] == A_CTRL && pwdata[C_BUF_POP]
                 && r.cnt != '0) begin
      next_r.rp = r.rp + BUF_AW'(1);
      next_r.cnt = r.cnt - (BUF_AW+1)'(1);
    end

    next_r.rdata = 32'h0;
    if (psel && !penable && !pwrite) begin
      unique case (paddr[7:0])
        A_CTRL: next_r.rdata = 32'({r.sysblk_param, r.diag_en});
        A_STATUS: next_r.rdata = 32'({r.reported, r.sync_clr, r.cam_run,
                                      r.led});
        A_FAULTS: next_r.rdata = 32'(eff);
        A_INFO: next_r.rdata = 32'(r.mod_addr);
        A_BUF_CNT: next_r.rdata = 32'(r.cnt);
        A_BUF_DATA: next_r.rdata = 32'(buffer[r.rp]);
        A_FLAGS: next_r.rdata = 32'({r.job_err, r.data_err});
        default: next_r.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.run_prev <= 1'b0;
      r.mod_addr <= MOD_ADDR_DEF;
      r.cam_run <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Buffer storage is data only, no reset needed
  always_ff @(posedge pclk) begin
    if (buf_push) buffer[r.wp] <= buf_entry;
  end

  assign prdata = rd ? r.rdata : 32'h0;
  assign group_fault_indicator = r.led;
  assign cam_run = r.cam_run;
  assign sync_clear = r.sync_clr;
  assign control_out = r.ctl_out;
  assign dir_change_out = r.dir_out;
  assign func_sw_out = r.fsw_out;
  assign irq = r.irq;

endmodule : der_core
`default_nettype wire

// ==== testbench/der_core_chk.sv ====
/* Assertions on the der_core ports.
   Bound to every der_core instance. */
`timescale 1ns/1ps
`default_nettype none
module der_core_chk
  import der_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [NUM_FAULTS-1:0] fault_in,
  input wire logic host_run,
  input wire logic [7:0] func_sw_in,
  input wire logic [7:0] func_sw_out,
  input wire logic group_fault_indicator,
  input wire logic cam_run,
  input wire logic sync_clear,
  input wire der_irq_t irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Six cycles covers the two-stage sync of the run level
  sequence s_stopped;
    !host_run [*6];
  endsequence
  sequence s_event;
    irq.valid && irq.entering;
  endsequence
  property p_hold;
    $rose(group_fault_indicator) |-> group_fault_indicator [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("lamp short");
  property p_light;
    (|fault_in) [*4] |-> group_fault_indicator;
  endproperty
  a_light: assert property (p_light) else $error("lamp off");
  property p_halt;
    s_event |-> ##[0:3] !cam_run;
  endproperty
  a_halt: assert property (p_halt) else $error("cam runs");
  property p_sync;
    (|(fault_in & SYNC_MASK)) [*4] |-> sync_clear;
  endproperty
  a_sync: assert property (p_sync) else $error("sync kept");
  property p_sw;
    $past(presetn) |-> func_sw_out == $past(func_sw_in);
  endproperty
  a_sw: assert property (p_sw) else $error("switch lost");
  property p_ent;
    s_event |-> irq.module_defect;
  endproperty
  a_ent: assert property (p_ent) else $error("defect low");
  property p_clr;
    irq.valid && !irq.entering |-> !irq.module_defect;
  endproperty
  a_clr: assert property (p_clr) else $error("defect high");
  property p_stop;
    s_stopped |-> !irq.valid;
  endproperty
  a_stop: assert property (p_stop) else $error("event in stop");
endmodule : der_core_chk
bind der_core der_core_chk u_chk (.*);
`default_nettype wire

// ==== testbench/der_core_tb.sv ====
/* Self-checking bench for der_core with the host model.
   Lamp timer shortened to 60 cycles. */
`timescale 1ns/1ps
`default_nettype none
module der_core_tb
  import der_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, q, q0;
  logic pready, pslverr, host_run = 1, lim = 0, sim = 0, dir = 0;
  logic jde = 0, hce = 0, irq_ack, gfi, cam_run, sync_clear, dco;
  logic [7:0] ci = 0, co, fi = 0, fo;
  logic [11:0] fin = 0;
  der_irq_t irq, last;
  int fail_count = 0, checked = 0, ne = 0, nl = 0, n_ent, n_lv;
  der_core #(.LED_CYCLES(60)) u_der_core (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_in(fin), .host_run(host_run), .sw_limit_passed(lim),
    .sim_mode(sim), .control_in(ci), .dir_change_req(dir),
    .func_sw_in(fi), .write_job_data_err(jde), .host_comm_err(hce),
    .irq_ack(irq_ack), .group_fault_indicator(gfi), .cam_run(cam_run),
    .sync_clear(sync_clear), .control_out(co), .dir_change_out(dco),
    .func_sw_out(fo), .irq(irq));
  der_host_model u_der_host_model (.pclk(pclk), .presetn(presetn),
    .irq(irq), .irq_ack(irq_ack), .n_ent(n_ent), .n_lv(n_lv), .last(last));
  initial forever #2 pclk = ~pclk;
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    check(q, e);
  endtask : rd
  task automatic fset(input int b, input logic v);
    @(posedge pclk);
    fin[b] <= v;
    cyc(8);
  endtask : fset
  task automatic ev(input int de, input int dl);
    ne += de;
    nl += dl;
    check(n_ent, ne);
    check(n_lv, nl);
  endtask : ev
  task automatic t_regs;
    rd(A_INFO, 32'h10);
    rd(8'h40, 32'h0);
    apb(1'h1, A_CTRL, 32'h3);
    rd(A_CTRL, 32'h3);
  endtask : t_regs
  task automatic t_entry;
    ci <= 8'hA5;
    fi <= 8'h3C;
    cyc(3);
    check(co, 8'hA5);
    fset(F_OPERATING, 1'h1);
    ev(1, 0);
    check(last, 11'h710);
    check(cam_run, 1'h0);
    check(gfi, 1'h1);
    rd(A_BUF_CNT, 32'h1);
    rd(A_BUF_DATA, 32'h108);
    ci <= 8'h5A;
    fi <= 8'hC3;
    sim <= 1'h1;
    lim <= 1'h1;
    dir <= 1'h1;
    cyc(4);
    check(co === 8'h5A, 1'h0);
    check(dco, 1'h1);
    check(fo, 8'hC3);
  endtask : t_entry
  task automatic t_partial;
    fset(F_NO_FRONT, 1'h1);
    ev(1, 0);
    check(sync_clear, 1'h1);
    fset(F_OPERATING, 1'h0);
    ev(1, 0);
    apb(1'h0, A_BUF_CNT, 32'h0);
    q0 = q;
    fset(F_NO_FRONT, 1'h0);
    ev(0, 1);
    check(last, 11'h410);
    rd(A_BUF_CNT, q0);
    check(gfi, 1'h1);
    cyc(70);
    check(gfi, 1'h0);
    check(cam_run, 1'h1);
  endtask : t_partial
  task automatic t_stop;
    host_run <= 1'h0;
    fset(F_BAD_PARAM, 1'h1);
    ev(0, 0);
    host_run <= 1'h1;
    cyc(8);
    ev(1, 0);
    host_run <= 1'h0;
    fset(F_BAD_PARAM, 1'h0);
    host_run <= 1'h1;
    cyc(8);
    ev(0, 0);
  endtask : t_stop
  task automatic t_gate;
    // Events off, parameters from system block so every cause lights
    apb(1'h1, A_CTRL, 32'h2);
    for (int b = 0; b < NUM_FAULTS; b++) begin
      fset(b, 1'h1);
      check(gfi, 1'h1);
      fset(b, 1'h0);
      check(gfi, 1'h1);
      cyc(70);
      check(gfi, 1'h0);
    end
    ev(0, 0);
  endtask : t_gate
  task automatic t_flags;
    jde <= 1'h1;
    cyc(1);
    jde <= 1'h0;
    rd(A_FLAGS, 32'h1);
    hce <= 1'h1;
    cyc(1);
    hce <= 1'h0;
    rd(A_FLAGS, 32'h3);
    apb(1'h1, A_CTRL, 32'hB);
    rd(A_FLAGS, 32'h0);
  endtask : t_flags
  task automatic print_verdict;
    if (fail_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  initial begin
    cyc(5);
    presetn <= 1'h1;
    t_regs;
    t_entry;
    t_partial;
    t_stop;
    t_gate;
    t_flags;
    print_verdict;
  end
  initial begin
    cyc(6000);
    fail_count++;
    print_verdict;
  end
endmodule : der_core_tb
`default_nettype wire

// ==== testbench/der_host_model.sv ====
/* Host controller model: services each diagnostic event that is valid while irq_ack is low, counts them.
   Expects the irq port of der_core. */
`timescale 1ns/1ps
`default_nettype none
module der_host_model
  import der_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire der_irq_t irq,
  output logic irq_ack,
  output int n_ent,
  output int n_lv,
  output der_irq_t last
);
  // A held event is counted once, not again while acked
  wire logic take = irq.valid && !irq_ack;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ack <= 1'h0;
      n_ent <= 0;
      n_lv <= 0;
      last <= '0;
    end else begin
      irq_ack <= take;
      if (take) begin
        last <= irq;
        n_ent <= n_ent + int'(irq.entering);
        n_lv <= n_lv + int'(!irq.entering);
      end
    end
  end
endmodule : der_host_model
`default_nettype wire
